// File: core/lafl_pkg.sv
// Constants shared by the light alert flag logic and its link receiver.
// Assumes a 25 MHz system clock and a 16-bit exponent/mantissa result.
package lafl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the register bus
  // ----------------------------------------------------------------
  localparam logic [4:0] LAFL_OFS_CONFIG     = 5'h00;
  localparam logic [4:0] LAFL_OFS_LOW_LIMIT  = 5'h04;
  localparam logic [4:0] LAFL_OFS_HIGH_LIMIT = 5'h08;
  localparam logic [4:0] LAFL_OFS_RESULT     = 5'h0C;
  localparam logic [4:0] LAFL_OFS_ALERT_RESP = 5'h10;
  localparam logic [4:0] LAFL_OFS_STATUS     = 5'h14;

  // ----------------------------------------------------------------
  // Configuration and low-limit register field positions
  // ----------------------------------------------------------------
  localparam int LAFL_CFG_FAULT_LSB  = 0;
  localparam int LAFL_CFG_LEVEL_BIT  = 3;
  localparam int LAFL_CFG_LATCH_BIT  = 4;
  localparam int LAFL_CFG_FLAG_LO    = 5;
  localparam int LAFL_CFG_FLAG_HI    = 6;
  localparam int LAFL_CFG_READY_BIT  = 7;
  localparam int LAFL_CFG_MODE_LSB   = 9;
  localparam int LAFL_LOW_EXP_TOP    = 14;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  LAFL_RST_MODE      = 2'h0;
  localparam logic        LAFL_RST_LATCH     = 1'b1;
  localparam logic        LAFL_RST_LEVEL     = 1'b0;
  localparam logic [1:0]  LAFL_RST_FAULT     = 2'h0;
  localparam logic [15:0] LAFL_RST_LOW_LIMIT = 16'h0000;
  localparam logic [15:0] LAFL_RST_HIGH_LIM  = 16'hBFFF;
  localparam logic [1:0]  LAFL_MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0]  LAFL_EOC_CODE      = 2'h3;
  localparam logic [31:0] LAFL_READ_ZERO     = 32'h0000_0000;

  // Turns an exponent/mantissa code into a linear magnitude.
  function automatic logic [26:0] lafl_linear(input logic [15:0] code);
    lafl_linear = 27'(code[11:0]) << code[15:12];
  endfunction

  // Number of consecutive faults needed for a fault count setting.
  function automatic logic [3:0] lafl_needed(input logic [1:0] sel);
    case (sel)
      2'h0:    lafl_needed = 4'h1;
      2'h1:    lafl_needed = 4'h2;
      2'h2:    lafl_needed = 4'h4;
      default: lafl_needed = 4'h8;
    endcase
  endfunction

endpackage

// File: core/lafl_link_rx.sv
// Receives conversion completions from the conversion engine's link.
// Assumes conv_clk is slow against sys_clk and data is stable at its
// rising edge; every link pin is synchronised before use.
`timescale 1ns/10ps
`default_nettype none
module lafl_link_rx
  import lafl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n_int,
  input  wire logic        conv_clk,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  output logic             done_pulse,
  output logic [15:0]      result_word
);

  logic [1:0]  clk_sync_reg;
  logic        clk_seen_reg;
  logic [1:0]  done_sync_reg;
  logic [15:0] res_meta_reg;
  logic [15:0] res_sync_reg;
  logic        pulse_reg;
  logic        pulse_next;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic        link_rise;

  // ----------------------------------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      clk_sync_reg  <= 2'h0;
      clk_seen_reg  <= 1'b0;
      done_sync_reg <= 2'h0;
      res_meta_reg  <= 16'h0000;
      res_sync_reg  <= 16'h0000;
    end else begin
      clk_sync_reg  <= {clk_sync_reg[0], conv_clk};
      clk_seen_reg  <= clk_sync_reg[1];
      done_sync_reg <= {done_sync_reg[0], conv_done};
      res_meta_reg  <= conv_result;
      res_sync_reg  <= res_meta_reg;
    end
  end

  assign link_rise = clk_sync_reg[1] & ~clk_seen_reg;

  // ----------------------------------------------------------------
  // Capture at the link edge
  // ----------------------------------------------------------------
  always_comb begin
    pulse_next = link_rise & done_sync_reg[1];
    word_next  = pulse_next ? res_sync_reg : word_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pulse_reg <= 1'b0;
      word_reg  <= 16'h0000;
    end else begin
      pulse_reg <= pulse_next;
      word_reg  <= word_next;
    end
  end

  assign done_pulse  = pulse_reg;
  assign result_word = word_reg;

endmodule
`default_nettype wire

// File: core/lafl_alert_core.sv
// Alert and flag reporting for an ambient light sensor, with an
// Avalon-MM register slave. Assumes conversions arrive over a slow
// external link and that the host polls or watches the alert pin.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lafl_alert_core
  import lafl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        conv_clk,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  output logic [1:0]       conv_mode,
  output logic             alert_pin
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n_int;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Conversion link
  // ----------------------------------------------------------------
  logic        done_pulse;
  logic [15:0] result_word;

  lafl_link_rx u_link (
    .sys_clk     (sys_clk),
    .rst_n_int   (rst_n_int),
    .conv_clk    (conv_clk),
    .conv_done   (conv_done),
    .conv_result (conv_result),
    .done_pulse  (done_pulse),
    .result_word (result_word)
  );

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle, so read data can be
  // registered from a stable address without a second pipeline stage.
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        do_read;
  logic        do_write;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  // Read side effects land on the edge that loads the read data, so a
  // flag or ready set during the wait cycle survives for the next read.
  assign do_read  = avs_read & ~ack_reg;
  assign do_write = avs_write & ack_reg;

  // ----------------------------------------------------------------
  // Register and reporting state
  // ----------------------------------------------------------------
  logic [1:0]  mode_reg,   mode_next;
  logic        latch_reg,  latch_next;
  logic        level_reg,  level_next;
  logic [1:0]  fault_reg,  fault_next;
  logic [15:0] low_reg,    low_next;
  logic [15:0] high_reg,   high_next;
  logic        fh_reg,     fh_next;
  logic        fl_reg,     fl_next;
  logic        ready_reg,  ready_next;
  logic        alert_reg,  alert_next;
  logic        pin_reg,    pin_next;
  logic [3:0]  hcnt_reg,   hcnt_next;
  logic [3:0]  lcnt_reg,   lcnt_next;

  logic        eoc_mode;
  logic        cfg_read;
  logic        cfg_write;
  logic        resp_write;
  logic        above;
  logic        below;
  logic        qual_hi;
  logic        qual_lo;
  logic [3:0]  needed;
  logic [31:0] cfg_word;

  assign eoc_mode = low_reg[LAFL_LOW_EXP_TOP +: 2] == LAFL_EOC_CODE;

  assign cfg_read   = do_read  && avs_address == LAFL_OFS_CONFIG;
  assign cfg_write  = do_write && avs_address == LAFL_OFS_CONFIG;
  assign resp_write = do_write && avs_address == LAFL_OFS_ALERT_RESP;

  assign above  = lafl_linear(result_word) > lafl_linear(high_reg);
  assign below  = lafl_linear(result_word) < lafl_linear(low_reg);
  assign needed = lafl_needed(fault_reg);

  always_comb begin
    cfg_word = LAFL_READ_ZERO;
    cfg_word[LAFL_CFG_MODE_LSB +: 2]  = mode_reg;
    cfg_word[LAFL_CFG_READY_BIT]      = ready_reg;
    cfg_word[LAFL_CFG_FLAG_HI]        = fh_reg;
    cfg_word[LAFL_CFG_FLAG_LO]        = fl_reg;
    cfg_word[LAFL_CFG_LATCH_BIT]      = latch_reg;
    cfg_word[LAFL_CFG_LEVEL_BIT]      = level_reg;
    cfg_word[LAFL_CFG_FAULT_LSB +: 2] = fault_reg;
  end

  // ----------------------------------------------------------------
  // Next-state computation
  // ----------------------------------------------------------------
  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    mode_next  = mode_reg;
    latch_next = latch_reg;
    level_next = level_reg;
    fault_next = fault_reg;
    low_next   = low_reg;
    high_next  = high_reg;
    fh_next    = fh_reg;
    fl_next    = fl_reg;
    ready_next = ready_reg;
    alert_next = alert_reg;
    hcnt_next  = hcnt_reg;
    lcnt_next  = lcnt_reg;
    qual_hi    = 1'b0;
    qual_lo    = 1'b0;

    if (ack_next && avs_read) begin
      case (avs_address)
        LAFL_OFS_CONFIG:     rdata_next = cfg_word;
        LAFL_OFS_LOW_LIMIT:  rdata_next = {16'h0000, low_reg};
        LAFL_OFS_HIGH_LIMIT: rdata_next = {16'h0000, high_reg};
        LAFL_OFS_RESULT:     rdata_next = {16'h0000, result_word};
        LAFL_OFS_ALERT_RESP: rdata_next = {31'h0000_0000, fh_reg};
        LAFL_OFS_STATUS:     rdata_next = {31'h0000_0000, alert_reg};
        default:             rdata_next = LAFL_READ_ZERO;
      endcase
    end

    if (do_write) begin
      case (avs_address)
        LAFL_OFS_LOW_LIMIT:  low_next  = avs_writedata[15:0];
        LAFL_OFS_HIGH_LIMIT: high_next = avs_writedata[15:0];
        default:             low_next  = low_reg;
      endcase
    end

    // Clearing effects come first so a completion in the same cycle
    // still sets its flags and ready afterwards.
    if (cfg_read) begin
      ready_next = 1'b0;
      if (latch_reg) begin
        fh_next    = 1'b0;
        fl_next    = 1'b0;
        alert_next = 1'b0;
      end else if (eoc_mode) begin
        alert_next = 1'b0;
      end
    end

    if (cfg_write) begin
      mode_next  = avs_writedata[LAFL_CFG_MODE_LSB +: 2];
      latch_next = avs_writedata[LAFL_CFG_LATCH_BIT];
      level_next = avs_writedata[LAFL_CFG_LEVEL_BIT];
      fault_next = avs_writedata[LAFL_CFG_FAULT_LSB +: 2];
      if (mode_next != LAFL_MODE_SHUTDOWN) begin
        ready_next = 1'b0;
        if (!latch_reg && eoc_mode) begin
          alert_next = 1'b0;
        end
      end
      // Latch 1 to 0 releases the alert unless eoc_mode is set
      if (latch_reg && !latch_next && !eoc_mode) begin
        alert_next = 1'b0;
      end
    end

    if (resp_write && latch_reg) begin
      alert_next = 1'b0;
    end

    if (done_pulse) begin
      hcnt_next = above ? ((hcnt_reg < needed) ? hcnt_reg + 4'h1 : needed)
                        : 4'h0;
      lcnt_next = below ? ((lcnt_reg < needed) ? lcnt_reg + 4'h1 : needed)
                        : 4'h0;
      qual_hi   = above && hcnt_next >= needed;
      qual_lo   = below && lcnt_next >= needed;
      ready_next = 1'b1;
      if (latch_reg) begin
        if (qual_hi) begin
          fh_next    = 1'b1;
          alert_next = 1'b1;
        end
        if (qual_lo) begin
          fl_next    = 1'b1;
          alert_next = 1'b1;
        end
      end else if (qual_hi) begin
        fh_next    = 1'b1;
        fl_next    = 1'b0;
        alert_next = 1'b1;
      end else if (qual_lo) begin
        fh_next    = 1'b0;
        fl_next    = 1'b1;
        alert_next = eoc_mode;
      end
      if (eoc_mode) begin
        alert_next = 1'b1;
      end
    end

    // Pin level from active level select
    pin_next = ~(alert_next ^ level_next);
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      ack_reg   <= 1'b0;
      rdata_reg <= LAFL_READ_ZERO;
      mode_reg  <= LAFL_RST_MODE;
      latch_reg <= LAFL_RST_LATCH;
      level_reg <= LAFL_RST_LEVEL;
      fault_reg <= LAFL_RST_FAULT;
      low_reg   <= LAFL_RST_LOW_LIMIT;
      high_reg  <= LAFL_RST_HIGH_LIM;
      fh_reg    <= 1'b0;
      fl_reg    <= 1'b0;
      ready_reg <= 1'b0;
      alert_reg <= 1'b0;
      pin_reg   <= ~LAFL_RST_LEVEL;
      hcnt_reg  <= 4'h0;
      lcnt_reg  <= 4'h0;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      mode_reg  <= mode_next;
      latch_reg <= latch_next;
      level_reg <= level_next;
      fault_reg <= fault_next;
      low_reg   <= low_next;
      high_reg  <= high_next;
      fh_reg    <= fh_next;
      fl_reg    <= fl_next;
      ready_reg <= ready_next;
      alert_reg <= alert_next;
      pin_reg   <= pin_next;
      hcnt_reg  <= hcnt_next;
      lcnt_reg  <= lcnt_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign conv_mode    = mode_reg;
  assign alert_pin    = pin_reg;

endmodule
`default_nettype wire

// File: tb/lafl_alert_props.sv
// Port checker for the alert core, bound into the core.
// Assumes bus requests and conversions do not overlap in time.
`timescale 1ns/10ps
`default_nettype none
module lafl_alert_props
  import lafl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        conv_clk,
  input wire logic        conv_done,
  input wire logic        alert_pin
);
  logic lvl_reg;
  logic lat_reg;
  logic eoc_reg;
  logic lvl_next;
  logic lat_next;
  logic eoc_next;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && !avs_waitrequest;
  // Shadow of the level and latch bits and the low-limit eoc code, so the checks know the reporting style.
  always_comb begin
    lvl_next = lvl_reg;
    lat_next = lat_reg;
    eoc_next = eoc_reg;
    if (wr_ok && avs_address == LAFL_OFS_CONFIG) begin
      lvl_next = avs_writedata[LAFL_CFG_LEVEL_BIT];
      lat_next = avs_writedata[LAFL_CFG_LATCH_BIT];
    end
    if (wr_ok && avs_address == LAFL_OFS_LOW_LIMIT)
      eoc_next = &avs_writedata[15:LAFL_LOW_EXP_TOP];
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_reg <= LAFL_RST_LEVEL;
      lat_reg <= LAFL_RST_LATCH;
      eoc_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      lat_reg <= lat_next;
      eoc_reg <= eoc_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest held too long");
  AST_UNMAPPED_ZERO: assert property (rd_ok && avs_address > LAFL_OFS_STATUS
    |-> avs_readdata == LAFL_READ_ZERO) else $error("unmapped read not 0");
  AST_PIN_QUIET: assert property (
    (!avs_read && !avs_write && !conv_clk)[*8] |=> $stable(alert_pin))
    else $error("alert pin moved without cause");
  AST_PIN_LEVEL: assert property (
    rd_ok && avs_address == LAFL_OFS_STATUS && $stable(alert_pin)
    |-> alert_pin == !(avs_readdata[0] ^ lvl_reg))
    else $error("alert pin level wrong");
  AST_EOC_EVERY: assert property (
    eoc_reg && conv_done && $rose(conv_clk) |-> ##[3:8] alert_pin == lvl_reg)
    else $error("no alert after completion");
  AST_RESP_IGNORED: assert property (
    wr_ok && avs_address == LAFL_OFS_ALERT_RESP && !lat_reg
    |-> $stable(alert_pin)[*3]) else $error("alert response not ignored");
  AST_EOC_READ: assert property (
    eoc_reg && lat_reg && rd_ok && avs_address == LAFL_OFS_CONFIG
    |-> ##[1:2] alert_pin != lvl_reg) else $error("read kept alert");
  AST_EOC_WRITE: assert property (
    eoc_reg && !lat_reg && wr_ok && avs_address == LAFL_OFS_CONFIG &&
    avs_writedata[LAFL_CFG_MODE_LSB +: 2] != LAFL_MODE_SHUTDOWN &&
    !avs_writedata[LAFL_CFG_LATCH_BIT]
    |-> ##[1:2] alert_pin != lvl_reg) else $error("write kept alert");
  cover property (wr_ok && avs_address == LAFL_OFS_ALERT_RESP);
  cover property (eoc_reg && $rose(conv_clk));
  cover property (rd_ok && avs_address == LAFL_OFS_CONFIG);
endmodule
bind lafl_alert_core lafl_alert_props lafl_alert_props_inst (
  .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .conv_clk(conv_clk),
  .conv_done(conv_done), .alert_pin(alert_pin)
);
`default_nettype wire

// File: tb/lafl_conv_model.sv
// Conversion engine model driving the completion link.
// Assumes a 40 ns sys_clk; one frame gives a 320 ns link clock period.
`timescale 1ns/10ps
`default_nettype none
module lafl_conv_model (
  input  wire logic   sys_clk,
  output logic        conv_clk,
  output logic        conv_done,
  output logic [15:0] conv_result
);
  initial begin
    conv_clk = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h5A5A;
  end
  // The link clock stands still between frames; data is inverted after.
  task automatic convert(input logic [15:0] res);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    conv_result <= res;
    repeat (4) @(posedge sys_clk);
    conv_clk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    conv_clk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    conv_done <= 1'b0;
    conv_result <= ~res;
  endtask
endmodule
`default_nettype wire

// File: tb/lafl_alert_core_test.sv
// Self-checking bench for the alert core.
// Assumes the conversion model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module lafl_alert_core_test import lafl_pkg::*;;
  logic        sys_clk;
  logic        rstn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        conv_clk;
  logic        conv_done;
  logic [15:0] conv_result;
  logic [1:0]  conv_mode;
  logic        alert_pin;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          fail_count;
  int          cmp_count;
  int          cyc;
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  lafl_alert_core lafl_alert_core_inst (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_clk(conv_clk),
    .conv_done(conv_done), .conv_result(conv_result),
    .conv_mode(conv_mode), .alert_pin(alert_pin)
  );
  lafl_conv_model lafl_conv_model_inst (
    .sys_clk(sys_clk), .conv_clk(conv_clk), .conv_done(conv_done),
    .conv_result(conv_result)
  );
  task automatic check(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read data are judged at the accepting edge against the oldest note.
  always @(posedge sys_clk) begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0) begin
      check("readdata", avs_readdata & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // An idle edge first, so a request is never dropped and raised at once.
  task automatic bus(input logic r, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic cf(input logic r, h, l);
    rd(LAFL_OFS_CONFIG, 32'h0000_00E0, {24'h00_0000, r, h, l, 5'h00});
  endtask
  task automatic st(input logic e);
    rd(LAFL_OFS_STATUS, 32'h0000_0001, {31'h0000_0000, e});
  endtask
  // Pin and mode are looked at on the falling edge, once they have settled.
  task automatic pn(input logic e);
    @(negedge sys_clk);
    check("alert_pin", {31'h0000_0000, alert_pin}, {31'h0000_0000, e});
  endtask
  task automatic md(input logic [1:0] e);
    @(negedge sys_clk);
    check("conv_mode", {30'h0000_0000, conv_mode}, {30'h0000_0000, e});
  endtask
  function automatic logic [31:0] cfg(logic [1:0] m, logic l, v,
                                      logic [1:0] f);
    cfg = {21'h00_0000, m, 4'h0, l, v, 1'b0, f};
  endfunction
  // Limits: low 0x80, high 0x200 linear; k picks mid, high or low light.
  task automatic cv(input logic [1:0] k);
    logic [11:0] m;
    m = 12'($urandom_range(255));
    case (k)
      2'h0: lafl_conv_model_inst.convert({4'h0, 12'h080 + m});
      2'h1: lafl_conv_model_inst.convert({4'h2, 12'h100 + m});
      default: lafl_conv_model_inst.convert({4'h0, 6'h00, m[5:0]});
    endcase
    repeat (4) @(posedge sys_clk);
  endtask
  initial begin
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    void'($urandom(51762));
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(5'h18, 32'hFFFF_FFFF, LAFL_READ_ZERO);
    rd(LAFL_OFS_CONFIG, 32'h0000_06FB, 32'h0000_0010);
    rd(LAFL_OFS_HIGH_LIMIT, 32'h0000_FFFF, {16'h0000, LAFL_RST_HIGH_LIM});
    pn(1'b1);
    wr(LAFL_OFS_HIGH_LIMIT, 32'h0000_1100);
    wr(LAFL_OFS_LOW_LIMIT, 32'h0000_0080);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b0, 1'b0, 2'h0));
    cv(2'h1);
    pn(1'b0);
    cf(1'b1, 1'b1, 1'b0);
    cf(1'b0, 1'b1, 1'b0);
    st(1'b1);
    wr(LAFL_OFS_ALERT_RESP, 32'h0000_0001);
    st(1'b1);
    cv(2'h0);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b0, 1'b0, 2'h0));
    cf(1'b0, 1'b1, 1'b0);
    cv(2'h2);
    pn(1'b1);
    cf(1'b1, 1'b0, 1'b1);
    cv(2'h0);
    wr(LAFL_OFS_CONFIG, cfg(2'h0, 1'b0, 1'b0, 2'h1));
    md(2'h0);
    cf(1'b1, 1'b0, 1'b1);
    wr(LAFL_OFS_CONFIG, cfg(2'h2, 1'b0, 1'b0, 2'h1));
    md(2'h2);
    cv(2'h1);
    cv(2'h0);
    cv(2'h1);
    cf(1'b1, 1'b0, 1'b1);
    cv(2'h1);
    cf(1'b1, 1'b1, 1'b0);
    wr(LAFL_OFS_LOW_LIMIT, 32'h0000_C000);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b1, 1'b0, 2'h0));
    cv(2'h0);
    st(1'b1);
    wr(LAFL_OFS_ALERT_RESP, 32'h0000_0001);
    st(1'b0);
    cf(1'b1, 1'b1, 1'b0);
    cf(1'b0, 1'b0, 1'b0);
    cv(2'h1);
    st(1'b1);
    cf(1'b1, 1'b1, 1'b0);
    st(1'b0);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b0, 1'b1, 2'h0));
    cv(2'h1);
    pn(1'b1);
    wr(LAFL_OFS_ALERT_RESP, 32'h0000_0001);
    st(1'b1);
    cf(1'b1, 1'b1, 1'b0);
    st(1'b0);
    cv(2'h0);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b0, 1'b1, 2'h0));
    st(1'b0);
    cf(1'b0, 1'b1, 1'b0);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b1, 1'b0, 2'h0));
    cv(2'h0);
    pn(1'b0);
    wr(LAFL_OFS_LOW_LIMIT, 32'h0000_0080);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b0, 1'b0, 2'h0));
    pn(1'b1);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b1, 1'b0, 2'h0));
    cv(2'h0);
    pn(1'b1);
    rd(LAFL_OFS_LOW_LIMIT, 32'h0000_FFFF, 32'h0000_0080);
    cv(2'h2);
    pn(1'b0);
    cf(1'b1, 1'b1, 1'b1);
    pn(1'b1);
    wr(LAFL_OFS_CONFIG, cfg(2'h1, 1'b1, 1'b0, 2'h2));
    repeat (3) cv(2'h1);
    cf(1'b1, 1'b0, 1'b0);
    cv(2'h1);
    rd(LAFL_OFS_ALERT_RESP, 32'h0000_0001, 32'h0000_0001);
    cf(1'b1, 1'b1, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
